// ---- rtl/flash_block_protection.v ----
// flash array with block erase and pair protection
// Overview of operation
// - 64 kb array of individually erasable 1 kb blocks
// - completed erase leaves block all ones
// - protection per 2 kb pair of blocks
// - read-only pair refuses erase and program
// - execute-only pair refuses erase and program
// - execute-only pair serves instruction fetches only
`timescale 1ns/1ps
`include "flash_prot_map.vh"
module flash_block_protection
(
	input wire clk,
	input wire rst,
	input wire [63:0] attr_in,
	input wire fetch_req,
	input wire [15:0] fetch_addr,
	output reg [31:0] fetch_data,
	output reg fetch_valid,
	input wire data_req,
	input wire data_dbg,
	input wire [15:0] data_addr,
	output reg [31:0] data_rdata,
	output reg data_valid,
	output reg data_denied,
	input wire prog_req,
	input wire [15:0] prog_addr,
	input wire [31:0] prog_data,
	input wire erase_req,
	input wire [15:0] erase_addr,
	output wire busy,
	output reg done,
	output reg refused
);
	// ----------------------------------------
	// storage and attributes
	// ----------------------------------------
	// one word per 4-byte flash location
	reg [31:0] mem [0:`FP_WORDS-1];

	// sequencer state codes
	localparam ST_IDLE = `FP_ST_IDLE;
	localparam ST_ERASE = `FP_ST_ERASE;

	// sequencer registers and their next values
	reg [1:0] state_r;
	reg [1:0] state_nxt;
	reg [`FP_BLK_W-1:0] blk_r;
	reg [`FP_BLK_W-1:0] blk_nxt;
	reg [`FP_BLK_WORDS_W-1:0] cnt_r;
	reg [`FP_BLK_WORDS_W-1:0] cnt_nxt;
	reg done_nxt;
	reg refused_nxt;
	reg data_valid_nxt;
	reg data_denied_nxt;

	// lock flags, one bit per 2 kb pair
	wire [31:0] no_write;
	wire [31:0] fetch_only;

	// attribute register and per-pair decode
	pair_attr u_attr
	(
		.clk(clk),
		.rst(rst),
		.attr_in(attr_in),
		.no_write(no_write),
		.fetch_only(fetch_only)
	);

	// ----------------------------------------
	// address decode
	// ----------------------------------------
	// pair index is the 2 kb slot of each address
	wire [`FP_PAIR_W-1:0] d_pair = data_addr[`FP_ADDR_W-1:`FP_PAIR_LSB];
	wire [`FP_PAIR_W-1:0] p_pair = prog_addr[`FP_ADDR_W-1:`FP_PAIR_LSB];
	wire [`FP_PAIR_W-1:0] e_pair = erase_addr[`FP_ADDR_W-1:`FP_PAIR_LSB];

	// word index drops the byte lane bits
	wire [`FP_WORD_AW-1:0] f_word = fetch_addr[`FP_ADDR_W-1:`FP_WORD_LSB];
	wire [`FP_WORD_AW-1:0] d_word = data_addr[`FP_ADDR_W-1:`FP_WORD_LSB];
	wire [`FP_WORD_AW-1:0] p_word = prog_addr[`FP_ADDR_W-1:`FP_WORD_LSB];
	wire [`FP_WORD_AW-1:0] e_word = {blk_r, cnt_r}; // erase walk position

	// access decisions; debug reads share the data gate
	wire idle = (state_r == ST_IDLE);
	wire d_block = fetch_only[d_pair];
	wire p_ok = idle && prog_req && !no_write[p_pair];
	wire e_ok = idle && erase_req && !prog_req && !no_write[e_pair];

	// one shared write port: program word or erase fill
	wire w_en = p_ok || !idle;
	wire [`FP_WORD_AW-1:0] w_word = p_ok ? p_word : e_word;
	wire [31:0] w_data = p_ok ? prog_data : `FP_ERASED;

	// erase in progress
	assign busy = !idle;

	// ----------------------------------------
	// read ports
	// ----------------------------------------
	// data and debug answer flags: refuse execute-only pairs
	always @*
	begin
		data_valid_nxt = 1'b0;
		data_denied_nxt = 1'b0;
		if (data_req)
		begin
			if (d_block)
				data_denied_nxt = 1'b1;
			else
				data_valid_nxt = 1'b1;
		end
	end

	// fetch port: every fetch is served from the array
	always @(posedge clk)
	begin
		if (rst)
		begin
			fetch_data <= `FP_ZERO;
			fetch_valid <= 1'b0;
		end
		else
		begin
			fetch_valid <= fetch_req;
			if (fetch_req)
				fetch_data <= mem[f_word];
		end
	end

	// data port: a refused read returns zero, never array contents
	always @(posedge clk)
	begin
		if (rst)
		begin
			data_rdata <= `FP_ZERO;
			data_valid <= 1'b0;
			data_denied <= 1'b0;
		end
		else
		begin
			data_valid <= data_valid_nxt;
			data_denied <= data_denied_nxt;
			if (data_req && d_block)
				data_rdata <= `FP_ZERO;
			else if (data_req)
				data_rdata <= mem[d_word];
		end
	end

	// ----------------------------------------
	// program and erase
	// ----------------------------------------
	// erase walks one 1 kb block only; program writes one word
	always @(posedge clk)
	begin
		if (w_en)
			mem[w_word] <= w_data;
	end

	// ----------------------------------------
	// erase sequencer
	// ----------------------------------------
	// next state, erase position and status pulses
	always @*
	begin
		state_nxt = state_r;
		blk_nxt = blk_r;
		cnt_nxt = cnt_r;
		done_nxt = 1'b0;
		refused_nxt = 1'b0;
		case (state_r)
			ST_IDLE:
			begin
				if (prog_req)
				begin
					// program wins over a same-cycle erase
					done_nxt = p_ok;
					refused_nxt = !p_ok;
				end
				else if (erase_req)
				begin
					refused_nxt = !e_ok;
					if (e_ok)
					begin
						state_nxt = ST_ERASE;
						blk_nxt = erase_addr[`FP_ADDR_W-1:`FP_BLK_LSB];
						cnt_nxt = {`FP_BLK_WORDS_W{1'b0}};
					end
				end
			end
			ST_ERASE:
			begin
				// last word of the block ends the walk
				cnt_nxt = cnt_r + `FP_CNT_ONE;
				if (cnt_r == `FP_BLK_LAST)
				begin
					state_nxt = ST_IDLE;
					done_nxt = 1'b1;
				end
			end
			default:
				state_nxt = ST_IDLE;
		endcase
	end

	// sequencer registers; status pulses last one cycle
	always @(posedge clk)
	begin
		if (rst)
		begin
			state_r <= ST_IDLE;
			blk_r <= {`FP_BLK_W{1'b0}};
			cnt_r <= {`FP_BLK_WORDS_W{1'b0}};
			done <= 1'b0;
			refused <= 1'b0;
		end
		else
		begin
			state_r <= state_nxt;
			blk_r <= blk_nxt;
			cnt_r <= cnt_nxt;
			done <= done_nxt;
			refused <= refused_nxt;
		end
	end
endmodule

// ---- rtl/flash_prot_map.vh ----
// constants for the flash block protection logic
`ifndef FLASH_PROT_MAP_VH
`define FLASH_PROT_MAP_VH
`define FP_ADDR_W 16
`define FP_WORD_AW 14
`define FP_WORDS 16384
`define FP_BLK_LSB 10
`define FP_BLK_W 6
`define FP_PAIR_LSB 11
`define FP_PAIRS 32
`define FP_PAIR_W 5
`define FP_BLK_WORDS 256
`define FP_BLK_WORDS_W 8
`define FP_ERASED 32'hffffffff
`define FP_ZERO 32'h00000000
`define FP_WORD_LSB 2
`define FP_ST_IDLE 2'h0
`define FP_ST_ERASE 2'h1
`define FP_ATTR_OPEN 2'h0
`define FP_ATTR_RO 2'h1
`define FP_ATTR_XO 2'h2
`define FP_ATTR_RST 64'h0000000000000000
`define FP_BLK_LAST 8'hff
`define FP_CNT_ONE 8'h01
`endif

// ---- rtl/pair_attr.v ----
// per-pair protection attribute decode
`timescale 1ns/1ps
`include "flash_prot_map.vh"
module pair_attr
(
	input wire clk,
	input wire rst,
	input wire [63:0] attr_in,
	output wire [31:0] no_write,
	output wire [31:0] fetch_only
);
	reg [63:0] attr_r;

	// hold one attribute per 2 kb pair
	always @(posedge clk)
	begin
		if (rst)
			attr_r <= `FP_ATTR_RST;
		else
			attr_r <= attr_in;
	end

	genvar g;
	generate
		for (g = 0; g < `FP_PAIRS; g = g + 1)
		begin : pair
			// read-only and execute-only both lock writes
			assign no_write[g] = (attr_r[2*g+1:2*g] == `FP_ATTR_RO) ||
				(attr_r[2*g+1:2*g] == `FP_ATTR_XO);
			assign fetch_only[g] = (attr_r[2*g+1:2*g] == `FP_ATTR_XO);
		end
	endgenerate
endmodule

// ---- tb/core_model.sv ----
// core data-port model issuing one-cycle reads
`timescale 1ns/1ps
module core_model
(
	input wire clk,
	input wire go,
	input wire dbg,
	input wire [15:0] ra,
	output reg data_req = 0,
	output reg data_dbg = 0,
	output reg [15:0] data_addr = 0
);
	// address scrambled while idle
	always @(posedge clk)
	begin
		data_req <= go;
		data_dbg <= dbg;
		data_addr <= go ? ra : ~data_addr;
	end
endmodule

// ---- tb/flash_block_protection_chk.sv ----
// port checker for the flash block protection logic
`timescale 1ns/1ps
module flash_chk
(
	input wire clk,
	input wire rst,
	input wire fetch_req,
	input wire fetch_valid,
	input wire data_req,
	input wire data_valid,
	input wire data_denied,
	input wire prog_req,
	input wire erase_req,
	input wire busy,
	input wire done,
	input wire refused,
	input wire [63:0] attr_in,
	input wire [15:0] data_addr,
	input wire [15:0] prog_addr,
	input wire [15:0] erase_addr,
	input wire [31:0] data_rdata
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// attribute copy with the block's own one-cycle latency
	reg [63:0] attr_q;
	always @(posedge clk)
	begin
		if (rst)
			attr_q <= 64'h0;
		else
			attr_q <= attr_in;
	end
	// attribute of the addressed pair, and an erase the block would take
	wire [1:0] da = attr_q[{data_addr[15:11], 1'b0} +: 2];
	wire [1:0] pa = attr_q[{prog_addr[15:11], 1'b0} +: 2];
	wire [1:0] ea = attr_q[{erase_addr[15:11], 1'b0} +: 2];
	wire eo = erase_req && !prog_req && !busy;
	chk_read_once: assert property (data_req |=> data_valid ^ data_denied)
		else $error("read answer");
	chk_deny_blank: assert property (data_denied |-> data_rdata == 32'h0)
		else $error("denied data");
	chk_xo_read: assert property (data_req && da == 2'h2 && !$past(rst) |=> data_denied)
		else $error("xo read");
	chk_fetch_ok: assert property (fetch_req |=> fetch_valid) else $error("fetch");
	chk_ro_prog: assert property (prog_req && !busy && pa == 2'h1 && !$past(rst) |=> refused)
		else $error("ro prog");
	chk_xo_erase: assert property (eo && ea == 2'h2 && !$past(rst) |=> refused)
		else $error("xo erase");
	chk_erase_end: assert property ($fell(busy) |-> done) else $error("erase end");
	cover property (data_denied);
	cover property (refused);
	cover property ($fell(busy));
	cover property (fetch_valid);
endmodule
bind flash_block_protection flash_chk u_chk (.*);

// ---- tb/tb_flash_block_protection.sv ----
// bench for the flash block protection logic
`timescale 1ns/1ps
module tb_flash_block_protection;
	reg clk = 0, rst = 1, go = 0, dbg = 0, fetch_req = 0, prog_req = 0, erase_req = 0;
	reg [15:0] ra = 0, fetch_addr = 0, prog_addr = 0;
	reg [31:0] prog_data = 0;
	reg [63:0] attr = 0;
	wire [31:0] data_rdata, fetch_data;
	wire [15:0] data_addr;
	wire fetch_valid, data_req, data_dbg, data_valid, data_denied, done, refused, busy;
	integer errors = 0, checks = 0, n;
	initial forever #2.5 clk = ~clk;
	core_model cm
	(
		.clk(clk),
		.go(go),
		.dbg(dbg),
		.ra(ra),
		.data_req(data_req),
		.data_dbg(data_dbg),
		.data_addr(data_addr)
	);
	// program and erase share one address, never requested together
	flash_block_protection dut
	(
		.clk(clk),
		.rst(rst),
		.attr_in(attr),
		.fetch_req(fetch_req),
		.fetch_addr(fetch_addr),
		.fetch_data(fetch_data),
		.fetch_valid(fetch_valid),
		.data_req(data_req),
		.data_dbg(data_dbg),
		.data_addr(data_addr),
		.data_rdata(data_rdata),
		.data_valid(data_valid),
		.data_denied(data_denied),
		.prog_req(prog_req),
		.prog_addr(prog_addr),
		.prog_data(prog_data),
		.erase_req(erase_req),
		.erase_addr(prog_addr),
		.busy(busy),
		.done(done),
		.refused(refused)
	);
	task chk(input [33:0] s, e);
	begin
		checks = checks + 1;
		if (s !== e)
		begin
			errors = errors + 1;
			$display("BAD %0t got %h want %h", $time, s, e);
		end
	end
	endtask
	task end_sim;
	begin
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	end
	endtask
	// program word d (e=0) or erase (e=1), then expect done or refused
	task op(input e, input [15:0] a, input [31:0] d, input r);
	begin
		@(posedge clk);
		prog_addr <= a;
		prog_data <= d;
		prog_req <= !e;
		erase_req <= e;
		@(posedge clk);
		prog_req <= 0;
		erase_req <= 0;
		@(negedge clk);
		chk(busy, e && !r);
		for (n = 0; n < 300 && !done && !refused; n = n + 1)
			@(negedge clk);
		if (n == 300)
		begin
			errors = errors + 1;
			$display("BAD %0t no done or refused", $time);
			end_sim;
		end
		else
		begin
			chk({done, refused}, {!r, r});
			chk(n, (e && !r) ? 256 : 0);
		end
	end
	endtask
	// read through the core model; k selects a data compare
	task rdx(input [15:0] a, input d, input [31:0] x, input y, input k);
	begin
		@(posedge clk);
		ra <= a;
		dbg <= d;
		go <= 1;
		@(posedge clk);
		go <= 0;
		@(posedge clk);
		@(negedge clk);
		chk({data_denied, data_valid, k ? data_rdata : x}, {y, !y, x});
	end
	endtask
	task t_erase;
	begin
		op(0, 16'h0400, 32'h00000400, 0);
		op(1, 16'h0000, 32'h0, 0);
		rdx(16'h0000, 0, 32'hffffffff, 0, 1);
		rdx(16'h03fc, 0, 32'hffffffff, 0, 1);
		rdx(16'h0400, 0, 32'h00000400, 0, 1);
		$display("erase test end");
	end
	endtask
	task t_ro;
	begin
		op(0, 16'h07fc, 32'h000007fc, 0);
		op(0, 16'h0800, 32'h00000800, 0);
		@(posedge clk);
		attr <= 64'h04; // pair 1 read-only
		op(0, 16'h0800, 32'h0badf00d, 1);
		op(1, 16'h0ffc, 32'h0, 1);
		rdx(16'h0800, 0, 32'h00000800, 0, 1);
		rdx(16'h07fc, 0, 32'h000007fc, 0, 1);
		$display("read-only test end");
	end
	endtask
	task t_xo;
	begin
		op(0, 16'h1000, 32'h00001000, 0);
		@(posedge clk);
		attr <= 64'he4; // pair 2 execute-only, pair 3 code 3 stays open
		op(0, 16'h1000, 32'h0badf00d, 1);
		op(1, 16'h17fc, 32'h0, 1);
		op(0, 16'h1800, 32'h00001800, 0);
		rdx(16'h1000, 0, 32'h0, 1, 1);
		rdx(16'h1004, 1, 32'h0, 1, 1);
		rdx(16'h1800, 1, 32'h00001800, 0, 1);
		@(posedge clk);
		fetch_addr <= 16'h1000;
		fetch_req <= 1;
		@(posedge clk);
		fetch_req <= 0;
		@(negedge clk);
		chk({fetch_valid, fetch_data}, {1'b1, 32'h00001000});
		$display("execute-only test end");
	end
	endtask
	initial
	begin
		repeat (20) @(posedge clk);
		rst <= 0;
		t_erase;
		t_ro;
		t_xo;
		end_sim;
	end
endmodule
